// ---- rtl/rxb_pkg.sv ----
package rxb_pkg;

    // buffer geometry
    localparam int         BUF_DEPTH  = 66;
    localparam int         CNT_W      = 7;
    localparam logic [6:0] BUF_FULL_C = 7'h42;
    localparam logic [6:0] BUF_LAST_C = 7'h41;

    // pattern detector geometry
    localparam int         PAT_W      = 64;
    localparam logic [6:0] PAT_FILL_C = 7'h40;

    // pin map field positions: pins 0..3 in map a, pins 4..5 in map b
    localparam int MAP_A_PIN0_POS = 7;
    localparam int MAP_B_PIN4_POS = 7;
    localparam int MAP_FIELD_W    = 2;

    // pin map codes
    localparam logic [1:0] MAP_00 = 2'h0;
    localparam logic [1:0] MAP_01 = 2'h1;
    localparam logic [1:0] MAP_10 = 2'h2;
    localparam logic [1:0] MAP_11 = 2'h3;

    // operating modes, one-hot
    typedef enum logic [3:0] {
        MODE_SLEEP    = 4'h1,
        MODE_STDBY    = 4'h2,
        MODE_SYNTH_ON = 4'h4,
        MODE_RX       = 4'h8
    } rxb_mode_e;

    // status signals from the rest of the chip, same clock
    typedef struct packed {
        logic low_supply_flag;
        logic auto_sequence_flag;
        logic synth_lock_flag;
        logic mode_settled_flag;
        logic reference_clock_out;
        logic rx_timeout;
        logic rssi_above;
        logic receiver_settled;
        logic checksum_good;
        logic payload_done;
    } rxb_status_s;

    // pattern configuration register contents
    typedef struct packed {
        logic        pattern_enable;
        logic [2:0]  pattern_length;
        logic [2:0]  pattern_error_tolerance;
        logic [63:0] pattern_value;
    } rxb_pattern_cfg_s;

endpackage

// ---- rtl/rxb_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none
module rxb_fifo
    import rxb_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             push,
    input  wire logic [7:0]       push_data,
    input  wire logic             pop,
    input  wire logic             clear,
    output logic      [7:0]       rd_data,
    output logic      [CNT_W-1:0] count,
    output logic                  full,
    output logic                  empty
);

    typedef struct packed {
        logic [BUF_DEPTH-1:0][7:0] mem;
        logic [CNT_W-1:0]          wr_ptr;
        logic [CNT_W-1:0]          rd_ptr;
        logic [CNT_W-1:0]          count;
        logic [7:0]                rd_data;
    } rxb_fifo_s;

    rxb_fifo_s st;
    rxb_fifo_s next_st;
    logic      do_push;
    logic      do_pop;

    assign count   = st.count;
    assign rd_data = st.rd_data;
    assign full    = (st.count == BUF_FULL_C);
    assign empty   = (st.count == '0);
    // a push into a full buffer is dropped here; the caller flags it
    assign do_push = push && !full;
    assign do_pop  = pop && !empty;

    // one byte wide storage, 66 entries, clear beats both ports
    always_comb begin
        next_st = st;
        if (clear) begin
            next_st.wr_ptr = '0;
            next_st.rd_ptr = '0;
            next_st.count  = '0;
        end else begin
            if (do_push) begin
                next_st.mem[st.wr_ptr] = push_data;
                next_st.wr_ptr = (st.wr_ptr == BUF_LAST_C) ? '0 :
                                 st.wr_ptr + 7'h01;
            end
            if (do_pop) begin
                next_st.rd_data = st.mem[st.rd_ptr];
                next_st.rd_ptr  = (st.rd_ptr == BUF_LAST_C) ? '0 :
                                  st.rd_ptr + 7'h01;
            end
            if (do_push && !do_pop) begin
                next_st.count = st.count + 7'h01;
            end else if (do_pop && !do_push) begin
                next_st.count = st.count - 7'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    cap_bound_a: assert property (st.count <= BUF_FULL_C)
        else $error("buffer count above capacity");
    full_hold_a: assert property (
        full && push && !pop && !clear |=> full && $stable(st.wr_ptr))
        else $error("push into full buffer changed it");
    first_byte_a: assert property (
        empty && push && !clear |=> st.count == 7'h01)
        else $error("first byte not counted");

endmodule
`default_nettype wire

// ---- rtl/rxb_sync_detect.sv ----
`timescale 1ns/100ps
`default_nettype none
module rxb_sync_detect
    import rxb_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             bit_valid,
    input  wire logic             bit_in,
    input  wire logic             enable,
    input  wire rxb_pattern_cfg_s cfg,
    input  wire logic             clear,
    output logic                  match
);

    typedef struct packed {
        logic [PAT_W-1:0] shreg;
        logic [6:0]       fill;
        logic             match;
    } rxb_sync_s;

    rxb_sync_s        st;
    rxb_sync_s        next_st;
    logic [PAT_W-1:0] new_sh;
    logic [PAT_W-1:0] aligned;
    logic [PAT_W-1:0] mask;
    logic [5:0]       shamt;
    logic [6:0]       need;
    logic [6:0]       errs;
    logic             hit;

    assign match = st.match;

    // first pattern byte sits in the top byte, latest bit at bit 0
    always_comb begin
        new_sh  = {st.shreg[PAT_W-2:0], bit_in};
        shamt   = 6'({3'(3'h7 - cfg.pattern_length), 3'h0});
        aligned = cfg.pattern_value >> shamt;
        mask    = {PAT_W{1'b1}} >> shamt;
        need    = 7'({cfg.pattern_length, 3'h0}) + 7'h08;
        errs    = '0;
        for (int i = 0; i < PAT_W; i++) begin
            errs = errs + 7'((new_sh[i] ^ aligned[i]) & mask[i]);
        end
        hit = (st.fill >= need - 7'h01) &&
              (errs <= 7'(cfg.pattern_error_tolerance));
    end

    // sticky flag; a fresh hit wins over a clear in the same cycle
    always_comb begin
        next_st = st;
        if (clear) begin
            next_st.match = 1'b0;
        end
        if (bit_valid && enable) begin
            next_st.shreg = new_sh;
            if (st.fill != PAT_FILL_C) begin
                next_st.fill = st.fill + 7'h01;
            end
            if (hit) begin
                next_st.match = 1'b1;
            end
        end
        if (!enable) begin
            next_st.fill = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    tol_match_a: assert property (
        bit_valid && enable && hit |=> match)
        else $error("tolerated pattern not flagged");
    off_quiet_a: assert property (
        !enable && !match |=> !match)
        else $error("match rose while detection disabled");

endmodule
`default_nettype wire

// ---- rtl/rxb_core.sv ----
// Behaviour
// - shift demodulated bits into bytes, store bytes
// - buffer holds exactly 66 bytes
// - has-data flag high when any byte stored
// - has-data flag updates on chip select fall
// - full flag high when all entries used
// - byte into full buffer dropped, overrun set
// - level flag switching point is programmable
// - buffer cleared only entering receive; code also clears it on overrun clear
// - burst reads of buffer pop without incrementing
// - detection only when pattern enable set
// - detector compares stream continuously, sets match
// - earliest bit against first byte msb
// - match clears leaving receive or buffer empty
// - pattern length one to eight bytes
// - match tolerates zero to seven bit errors
// - six pins mapped by code, mode, data mode
// - continuous receive pin mapping for pins 0-2
// - packet pin mapping for pins 0 and 1
// - packet data only between settled and done
`timescale 1ns/100ps
`default_nettype none
module rxb_core
    import rxb_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire rxb_mode_e        op_mode,
    input  wire logic             packet_mode,
    input  wire logic             bit_sync_enable,
    input  wire logic             demod_data,
    input  wire logic             demod_bit_clk,
    input  wire logic             chip_select_n,
    input  wire logic             buffer_read_strobe,
    input  wire logic             overrun_clear,
    input  wire logic [6:0]       buffer_level_threshold,
    input  wire rxb_pattern_cfg_s pattern_cfg,
    input  wire logic [7:0]       pin_map_register_a,
    input  wire logic [7:0]       pin_map_register_b,
    input  wire rxb_status_s      status,
    output logic      [7:0]       buffer_read_data,
    output logic                  buffer_has_data_flag,
    output logic                  buffer_full_flag,
    output logic                  buffer_level_flag,
    output logic                  buffer_overrun_flag,
    output logic                  pattern_match_flag,
    output logic      [5:0]       io_pin
);

    typedef struct packed {
        logic       dat_s1;
        logic       dat_s2;
        logic       bck_s1;
        logic       bck_s2;
        logic       bck_s3;
        logic       cs_s1;
        logic       cs_s2;
        logic       cs_s3;
        rxb_mode_e  prev_mode;
        logic [7:0] bit_to_byte_shifter;
        logic [2:0] bit_cnt;
        logic       has_data;
        logic       full;
        logic       level;
        logic       overrun;
        logic       settled_d;
        logic       done_d;
        logic       data_window;
        logic       empty_d;
        logic [5:0] pins;
    } rxb_core_s;

    rxb_core_s        st;
    rxb_core_s        next_st;
    logic             in_rx;
    logic             bit_valid;
    logic             byte_done;
    logic             buf_push;
    logic             buf_clear;
    logic             buf_full;
    logic             buf_empty;
    logic [CNT_W-1:0] buf_count;
    logic             det_enable;
    logic             det_clear;
    logic             match;
    logic [5:0]       pin_val;
    logic [1:0]       code;
    logic             pkt_data;

    assign in_rx     = (op_mode == MODE_RX);
    // rising edge of the synchronised link clock marks a new bit
    assign bit_valid = st.bck_s2 && !st.bck_s3;
    assign byte_done = bit_valid && in_rx && packet_mode &&
                       (st.bit_cnt == 3'h7);
    // bytes reach the buffer once the pattern has been seen
    assign buf_push  = byte_done &&
                       (match || !pattern_cfg.pattern_enable);
    // entering receive from any other mode empties the buffer
    assign buf_clear = (in_rx && st.prev_mode != MODE_RX) ||
                       overrun_clear;
    // continuous mode needs the bit synchroniser for clean bits
    assign det_enable = pattern_cfg.pattern_enable && in_rx &&
                        (packet_mode || bit_sync_enable);
    // clear on the empty transition only: a level clear would drop the
    // match before the first payload byte can land
    assign det_clear  = !in_rx || (buf_empty && !st.empty_d);

    rxb_fifo u_fifo (
        .clk       (clk),
        .srst      (srst),
        .push      (buf_push),
        .push_data ({st.bit_to_byte_shifter[6:0], st.dat_s2}),
        .pop       (buffer_read_strobe),
        .clear     (buf_clear),
        .rd_data   (buffer_read_data),
        .count     (buf_count),
        .full      (buf_full),
        .empty     (buf_empty)
    );

    rxb_sync_detect u_sync (
        .clk       (clk),
        .srst      (srst),
        .bit_valid (bit_valid),
        .bit_in    (st.dat_s2),
        .enable    (det_enable),
        .cfg       (pattern_cfg),
        .clear     (det_clear),
        .match     (match)
    );

    assign buffer_has_data_flag = st.has_data;
    assign buffer_full_flag     = st.full;
    assign buffer_level_flag    = st.level;
    assign buffer_overrun_flag  = st.overrun;
    assign pattern_match_flag   = match;
    assign io_pin               = st.pins;
    // packet data only shown inside the settled..done window
    assign pkt_data = st.dat_s2 && st.data_window;

    // pin mux: code per pin, current mode, continuous or packet
    always_comb begin
        pin_val = '0;
        for (int p = 0; p < 6; p++) begin
            if (p < 4) begin
                code = pin_map_register_a[MAP_A_PIN0_POS - 2*p -:
                                          MAP_FIELD_W];
            end else begin
                code = pin_map_register_b[MAP_B_PIN4_POS - 2*(p-4) -:
                                          MAP_FIELD_W];
            end
            if (!packet_mode) begin
                unique case (p)
                    0: unique case (code)
                        MAP_00: pin_val[p] = in_rx ? match :
                            (op_mode == MODE_SYNTH_ON) &&
                            status.synth_lock_flag;
                        MAP_01: pin_val[p] = in_rx && status.rx_timeout;
                        MAP_10: pin_val[p] = in_rx ? status.rssi_above :
                            status.low_supply_flag;
                        MAP_11: pin_val[p] = status.mode_settled_flag;
                    endcase
                    1: unique case (code)
                        MAP_00: pin_val[p] = in_rx && st.bck_s2;
                        MAP_01: pin_val[p] = in_rx &&
                            status.receiver_settled;
                        MAP_10: pin_val[p] = status.low_supply_flag;
                        MAP_11: pin_val[p] = in_rx ? match :
                            (op_mode == MODE_SYNTH_ON) &&
                            status.synth_lock_flag;
                    endcase
                    2: pin_val[p] = in_rx && st.dat_s2;
                    3: unique case (code)
                        MAP_00: pin_val[p] = in_rx && status.rssi_above;
                        MAP_01: pin_val[p] = in_rx &&
                            status.receiver_settled;
                        MAP_10: pin_val[p] = status.auto_sequence_flag;
                        MAP_11: pin_val[p] = in_rx && status.rx_timeout;
                    endcase
                    4: unique case (code)
                        MAP_00: pin_val[p] = in_rx && status.rx_timeout;
                        MAP_01: pin_val[p] = in_rx &&
                            status.receiver_settled;
                        MAP_10: pin_val[p] = in_rx ? match :
                            status.low_supply_flag;
                        MAP_11: pin_val[p] = (in_rx ||
                            op_mode == MODE_SYNTH_ON) &&
                            status.synth_lock_flag;
                    endcase
                    default: unique case (code)
                        MAP_00: pin_val[p] = (op_mode != MODE_SLEEP) &&
                            status.reference_clock_out;
                        MAP_01: pin_val[p] = in_rx && status.rssi_above;
                        MAP_10: pin_val[p] = status.low_supply_flag;
                        MAP_11: pin_val[p] = status.mode_settled_flag;
                    endcase
                endcase
            end else begin
                unique case (p)
                    0: unique case (code)
                        MAP_00: pin_val[p] = in_rx && status.checksum_good;
                        MAP_01: pin_val[p] = in_rx && status.payload_done;
                        MAP_10: pin_val[p] = in_rx ? match :
                            status.low_supply_flag;
                        MAP_11: pin_val[p] = in_rx ? status.rssi_above :
                            (op_mode == MODE_SYNTH_ON) &&
                            status.synth_lock_flag;
                    endcase
                    1: unique case (code)
                        MAP_00: pin_val[p] = st.level;
                        MAP_01: pin_val[p] = st.full;
                        MAP_10: pin_val[p] = st.has_data;
                        MAP_11: pin_val[p] = in_rx ? status.rx_timeout :
                            (op_mode == MODE_SYNTH_ON) &&
                            status.synth_lock_flag;
                    endcase
                    2: unique case (code)
                        MAP_00: pin_val[p] = st.has_data;
                        MAP_01: pin_val[p] = in_rx && pkt_data;
                        MAP_10: pin_val[p] = status.low_supply_flag;
                        MAP_11: pin_val[p] = status.auto_sequence_flag;
                    endcase
                    3: unique case (code)
                        MAP_00: pin_val[p] = st.full;
                        MAP_01: pin_val[p] = in_rx && status.rssi_above;
                        MAP_10: pin_val[p] = in_rx ? match :
                            status.low_supply_flag;
                        MAP_11: pin_val[p] = (in_rx ||
                            op_mode == MODE_SYNTH_ON) &&
                            status.synth_lock_flag;
                    endcase
                    4: unique case (code)
                        MAP_00: pin_val[p] = in_rx && status.rx_timeout;
                        MAP_01: pin_val[p] = in_rx && status.rssi_above;
                        MAP_10: pin_val[p] = in_rx ?
                            status.receiver_settled :
                            status.low_supply_flag;
                        MAP_11: pin_val[p] = (in_rx ||
                            op_mode == MODE_SYNTH_ON) &&
                            status.synth_lock_flag;
                    endcase
                    default: unique case (code)
                        MAP_00: pin_val[p] = (op_mode != MODE_SLEEP) &&
                            status.reference_clock_out;
                        MAP_01: pin_val[p] = in_rx && pkt_data;
                        MAP_10: pin_val[p] = status.low_supply_flag;
                        MAP_11: pin_val[p] = status.mode_settled_flag;
                    endcase
                endcase
            end
        end
    end

    // synchronisers, shifter, flags and pin registers
    always_comb begin
        next_st        = st;
        next_st.dat_s1 = demod_data;
        next_st.dat_s2 = st.dat_s1;
        next_st.bck_s1 = demod_bit_clk;
        next_st.bck_s2 = st.bck_s1;
        next_st.bck_s3 = st.bck_s2;
        next_st.cs_s1  = chip_select_n;
        next_st.cs_s2  = st.cs_s1;
        next_st.cs_s3  = st.cs_s2;
        next_st.prev_mode = op_mode;
        if (!in_rx) begin
            next_st.bit_cnt = '0;
        end else if (bit_valid) begin
            next_st.bit_to_byte_shifter =
                {st.bit_to_byte_shifter[6:0], st.dat_s2};
            next_st.bit_cnt = st.bit_cnt + 3'h1;
        end
        // idle bus follows the buffer; a frame freezes the view taken
        // at its chip select fall, so a read in flight is finished
        if (st.cs_s2 || st.cs_s3) begin
            next_st.has_data = (buf_count != '0);
        end
        next_st.full  = (buf_count == BUF_FULL_C);
        next_st.level = (buf_count > buffer_level_threshold);
        // set wins over the host clear in the same cycle
        if (overrun_clear) begin
            next_st.overrun = 1'b0;
        end
        if (byte_done && buf_full &&
            (match || !pattern_cfg.pattern_enable)) begin
            next_st.overrun = 1'b1;
        end
        next_st.settled_d = status.receiver_settled;
        next_st.done_d    = status.payload_done;
        next_st.empty_d   = buf_empty;
        if (status.payload_done && !st.done_d) begin
            next_st.data_window = 1'b0;
        end else if (status.receiver_settled && !st.settled_d) begin
            next_st.data_window = 1'b1;
        end
        next_st.pins = pin_val;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '{prev_mode: MODE_SLEEP, cs_s1: 1'b1, cs_s2: 1'b1,
                    cs_s3: 1'b1, empty_d: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence rx_entry_s;
        in_rx && st.prev_mode != MODE_RX;
    endsequence

    rx_entry_clear_a: assert property (
        rx_entry_s |=> buf_empty)
        else $error("buffer not emptied on entry to receive");
    overrun_set_a: assert property (
        buf_push && buf_full |=> ##1 buffer_overrun_flag)
        else $error("dropped byte did not raise overrun");
    level_track_a: assert property (
        ##1 buffer_level_flag ==
        $past(buf_count > buffer_level_threshold))
        else $error("level flag disagrees with count");
    frame_hold_a: assert property (
        !st.cs_s2 && !st.cs_s3 |=> $stable(buffer_has_data_flag))
        else $error("has-data flag moved inside a frame");
    match_clear_a: assert property (
        !in_rx && !bit_valid |=> !pattern_match_flag)
        else $error("match flag survived leaving receive");
    empty_clear_a: assert property (
        buf_empty && !st.empty_d && !bit_valid |=> !pattern_match_flag)
        else $error("match flag survived buffer going empty");
    cont_data_pin_a: assert property (
        in_rx && !packet_mode |=> io_pin[2] == $past(st.dat_s2))
        else $error("continuous data pin wrong");

endmodule
`default_nettype wire

// ---- verification/rxb_link_src.sv ----
`timescale 1ns/100ps
`default_nettype none
// demodulator side: bit clock only runs inside a byte
module rxb_link_src (
    output logic bclk,
    output logic bdat
);
    // msb first, data changes while bit clock is low
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            bdat = b[i];
            #400 bclk = 1'b1;
            #400 bclk = 1'b0;
        end
        bdat = ~bdat; // stale bit is not held
    endtask
    initial begin
        bclk = 1'b0;
        bdat = 1'b0;
    end
endmodule
`default_nettype wire

// ---- verification/test_rxb_core.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_rxb_core;
    import rxb_pkg::*;
    logic clk = 1'b0, srst = 1'b1, rd = 1'b0, ovc = 1'b0;
    rxb_mode_e mode = MODE_RX;
    logic [6:0] thr = 7'h01;
    logic [7:0] map_a = 8'h00, map_b = 8'h00, rdata;
    logic pkt = 1'b1, csn = 1'b1;
    rxb_status_s sts = '0;
    logic has, full, lvl, ovr, pm, bclk, bdat;
    logic [5:0] pin;
    rxb_pattern_cfg_s cfg = '0;
    int n_fail = 0, n_tests = 0;
    always #50 clk = ~clk;
    rxb_link_src src_u (.bclk(bclk), .bdat(bdat));
    rxb_core dut_u (.clk(clk), .srst(srst), .op_mode(mode),
        .packet_mode(pkt), .bit_sync_enable(1'b1), .demod_data(bdat),
        .demod_bit_clk(bclk), .chip_select_n(csn),
        .buffer_read_strobe(rd), .overrun_clear(ovc),
        .buffer_level_threshold(thr), .pattern_cfg(cfg),
        .pin_map_register_a(map_a), .pin_map_register_b(map_b),
        .status(sts), .buffer_read_data(rdata), .buffer_has_data_flag(has),
        .buffer_full_flag(full), .buffer_level_flag(lvl),
        .buffer_overrun_flag(ovr), .pattern_match_flag(pm), .io_pin(pin));
    // inputs move on the falling edge only
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic check(input string what, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // sync delay plus push and flag latency
    task automatic put(input logic [7:0] b);
        src_u.send(b);
        cyc(6);
    endtask
    task automatic pop(input logic [7:0] exp);
        check("has_pre", 8'(has), 8'h01);
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        cyc(2);
        check("rdata", rdata, exp);
    endtask
    task automatic t_order;
        put(8'ha5);
        check("lvl1", 8'(lvl), 8'h00);
        check("has1", 8'(has), 8'h01);
        put(8'h3c);
        check("lvl2", 8'(lvl), 8'h01);
        check("pin_lvl", 8'(pin[1]), 8'h01);
        map_a = 8'h20;
        cyc(2);
        check("pin_has", 8'(pin[1]), 8'h01);
        pop(8'ha5);
        pop(8'h3c);
        check("has0", 8'(has), 8'h00);
        check("pin_has0", 8'(pin[1]), 8'h00);
    endtask
    task automatic t_fill;
        map_a = 8'h10;
        for (int i = 0; i < 66; i++) begin
            if (i == 65) check("full65", 8'(full), 8'h00);
            put(8'(i + 1));
        end
        check("full", 8'(full), 8'h01);
        check("pin_full", 8'(pin[1]), 8'h01);
        put(8'hee);
        check("ovr", 8'(ovr), 8'h01);
        pop(8'h01);
        ovc = 1'b1;
        cyc(1);
        ovc = 1'b0;
        cyc(2);
        check("ovr0", 8'(ovr), 8'h00);
        check("has_clr", 8'(has), 8'h00);
    endtask
    // leaving receive keeps bytes, entering receive clears them
    task automatic t_mode;
        put(8'h11);
        mode = MODE_SLEEP;
        sts.mode_settled_flag = 1'b1;
        map_b = 8'h30;
        cyc(3);
        check("kept", 8'(has), 8'h01);
        check("pin_rdy", 8'(pin[5]), 8'h01);
        mode = MODE_RX;
        cyc(3);
        check("cleared", 8'(has), 8'h00);
    endtask
    // one byte pattern, zero tolerance, then a payload byte
    task automatic t_sync;
        cfg = '{1'b1, 3'h0, 3'h0, 64'hb401_0203_0405_0607};
        put(8'h69);
        check("nomatch", 8'(has), 8'h00);
        put(8'hb4);
        put(8'h5a);
        check("match", 8'(pm), 8'h01);
        pop(8'h5a);
        cyc(2);
        check("match0", 8'(pm), 8'h00);
    endtask
    // a frame freezes the has-data view taken at chip select fall
    task automatic t_cs;
        cfg = '0;
        put(8'h77);
        csn = 1'b0;
        cyc(4);
        pop(8'h77);
        check("frozen", 8'(has), 8'h01);
        csn = 1'b1;
        cyc(4);
        check("unfrozen", 8'(has), 8'h00);
    endtask
    // continuous mode: pin 2 follows the data line, nothing stored
    task automatic t_cont;
        pkt = 1'b0;
        put(8'h5a);
        check("pin_dat1", 8'(pin[2]), 8'h01);
        check("no_store", 8'(has), 8'h00);
        put(8'ha5);
        check("pin_dat0", 8'(pin[2]), 8'h00);
        pkt = 1'b1;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        cyc(6);
        srst = 1'b0;
        cyc(2);
        t_order();
        t_fill();
        t_mode();
        t_sync();
        t_cs();
        t_cont();
        print_verdict();
    end
endmodule
`default_nettype wire
